// [core/serial_pkg.sv]
// Shared constants and types for the asynchronous/clocked serial unit.
// Assumes a 32-bit APB slave with one aligned word per register.
package serial_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BRATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RXDATA = 8'h14;
  localparam logic [7:0] OFS_ORDER = 8'h18;

  // Field positions in words that are not structs
  localparam int ORDER_BIT_POS = 3;
  localparam int BREAK_BIT_POS = 8;

  // Reset values
  localparam logic [7:0] BRATE_RESET = 8'hFF;

  // Bit timing on the 16x tick
  localparam logic [3:0] PHASE_SAMPLE = 4'h7;
  localparam logic [3:0] PHASE_MID = 4'h8;
  localparam logic [3:0] DATA_LAST_8 = 4'h7;
  localparam logic [3:0] DATA_LAST_7 = 4'h6;

  // Prescaler terminal counts: 2 * 4^n system clocks per step
  localparam logic [6:0] PRE_LAST_0 = 7'h01;
  localparam logic [6:0] PRE_LAST_1 = 7'h07;
  localparam logic [6:0] PRE_LAST_2 = 7'h1F;
  localparam logic [6:0] PRE_LAST_3 = 7'h7F;

  typedef struct packed {
    logic sync_mode;
    logic char_length_select;
    logic parity_enable;
    logic parity_odd;
    logic stop_two;
    logic multiproc_format_enable;
    logic [1:0] prescale_sel;
  } mode_t;

  typedef struct packed {
    logic tx_empty_irq_enable;
    logic rx_irq_enable;
    logic transmit_enable_bit;
    logic receive_enable_bit;
    logic mp_irq_enable;
    logic tx_end_irq_enable;
    logic clock_source_hi;
    logic clock_source_lo;
  } ctrl_t;

  typedef struct packed {
    logic tx_data_empty_flag;
    logic rx_data_full_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic tx_end_flag;
    logic mp_bit_received;
    logic mp_bit_transmit;
  } status_t;

  localparam mode_t MODE_RESET = '0;
  localparam ctrl_t CTRL_RESET = '0;
  localparam status_t STATUS_RESET = 8'h84;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;

endpackage : serial_pkg

// [core/serial_async_sync_framing.sv]
// Serial unit: asynchronous start/stop framing or clocked 8-bit transfer,
// register access over APB. Line pins are sampled as synchronous to pclk.
// Behaviour
// - Async data field is 8 bits when length bit is 0, 7 when 1.
// - Optional parity or multiprocessor bit after data, then 1 or 2 stop bits.
// - Twelve async formats; multiprocessor format replaces parity in its slot.
// - Receiver flags framing, parity, overrun errors and a line break.
// - Clocked mode: 8 data bits, no extras, only overrun is detected.
// - Async clock select: port, bit-rate clock out, or external 16x clock in.
// - Clocked mode: drive serial clock from generator, or use received clock.
// - Async line idles high; each character starts with a fall to low.
// - Frame is start, data, optional parity/mp bit, then high stop bits.
// - Receiver syncs to start edge and samples at 8th of 16 ticks.
// - Async clock output runs at bit rate, rising mid transmitted bit.
// - Clearing transmit enable sets tx-empty and resets the shift register.
// - Clearing receive enable keeps receive flags and received data.
// - Async clock output starts as soon as the control setting is written.
// - Enables hand pins to the unit; transmitter marks, receiver waits.
// - Clearing tx-empty loads the shifter, sets the flag and starts sending.
// - Bit rate = clock / (64 * 2^(2n-1) * (N+1)) with a 2-bit prescaler.
// - Order bit picks LSB-first or MSB-first for both directions.
`timescale 1ns/1ps
module serial_async_sync_framing
  import serial_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  input wire logic sck_in,
  output logic txd,
  output logic txd_oe,
  output logic sck_out,
  output logic sck_oe,
  // Transmit-empty request
  output logic tx_empty_irq
);

  // Reverse bit order when MSB first; a 7-bit character reverses within its low 7 bits
  function automatic logic [7:0] bit_order(input logic [7:0] d, input logic seven,
                                           input logic msb_first);
    logic [7:0] rev;
    rev = '0;
    for (int i = 0; i < 8; i++) rev[i] = d[7 - i];
    if (!msb_first) return d;
    return seven ? {1'b0, rev[7:1]} : rev;
  endfunction : bit_order

  // Prescaler terminal count from the 2-bit select
  function automatic logic [6:0] pre_last(input logic [1:0] n);
    case (n)
      2'h0: return PRE_LAST_0;
      2'h1: return PRE_LAST_1;
      2'h2: return PRE_LAST_2;
      default: return PRE_LAST_3;
    endcase
  endfunction : pre_last

  mode_t mode_r;
  ctrl_t ctrl_r;
  status_t stat_r;
  logic [7:0] brate_r, tdr_r, rdr_r, tsh_r;
  logic order_r, brk_r, pready_r, pslverr_r, txd_r, txd_oe_r, sck_out_r, sck_oe_r;
  logic irq_r, tpar_r, tmpb_r, tstop2_r, rxd_q, sck_in_q, sy_sck_r;
  logic [31:0] prdata_r;
  logic [6:0] pre_cnt;
  logic [7:0] brg_cnt;
  logic [3:0] tx_ph, rx_ph, tcnt, rcnt;
  logic [8:0] rsh_r;
  tx_state_t tx_state;
  rx_state_t rx_state;

  // Bus decode
  wire logic setup = psel & ~penable;
  wire logic wr = psel & penable & pready_r & pwrite;
  wire logic addr_ok = paddr inside {OFS_MODE, OFS_BRATE, OFS_CTRL, OFS_TXDATA,
                                     OFS_STATUS, OFS_RXDATA, OFS_ORDER};
  wire logic wr_mode = wr & (paddr == OFS_MODE);
  wire logic wr_brate = wr & (paddr == OFS_BRATE);
  wire logic wr_ctrl = wr & (paddr == OFS_CTRL);
  wire logic wr_tdr = wr & (paddr == OFS_TXDATA);
  wire logic wr_stat = wr & (paddr == OFS_STATUS);
  wire logic wr_order = wr & (paddr == OFS_ORDER);
  wire status_t wst = status_t'(pwdata[7:0]);
  wire logic [31:0] rd_data =
    (paddr == OFS_MODE) ? 32'(mode_r) :
    (paddr == OFS_BRATE) ? 32'(brate_r) :
    (paddr == OFS_CTRL) ? 32'(ctrl_r) :
    (paddr == OFS_TXDATA) ? 32'(tdr_r) :
    (paddr == OFS_STATUS) ? (32'(stat_r) | (32'(brk_r) << BREAK_BIT_POS)) :
    (paddr == OFS_RXDATA) ? 32'(rdr_r) :
    (paddr == OFS_ORDER) ? (32'(order_r) << ORDER_BIT_POS) : 32'h0000_0000;

  // Mode shorthands
  wire logic sync = mode_r.sync_mode;
  wire logic seven = ~sync & mode_r.char_length_select;
  wire logic extra = ~sync & (mode_r.parity_enable | mode_r.multiproc_format_enable);
  wire logic te = ctrl_r.transmit_enable_bit;
  wire logic re = ctrl_r.receive_enable_bit;
  wire logic ext_clk = ctrl_r.clock_source_hi;
  wire logic sync_int = sync & ~ext_clk;
  wire logic [3:0] data_last = seven ? DATA_LAST_7 : DATA_LAST_8;
  wire logic [3:0] rcnt_last = data_last + {3'h0, extra};

  // Baud generator: one tick per 2*4^n*(N+1) clocks, 16 ticks per async bit
  wire logic pre_wrap = (pre_cnt == pre_last(mode_r.prescale_sel));
  wire logic tick_int = pre_wrap & (brg_cnt == brate_r);
  wire logic sck_rise = sck_in & ~sck_in_q;
  wire logic sck_fall = ~sck_in & sck_in_q;
  wire logic tick16 = ext_clk ? sck_rise : tick_int;
  wire logic [3:0] tx_ph_nxt = tick16 ? tx_ph + 4'h1 : tx_ph;
  wire logic bit_start = tick16 & (&tx_ph);
  wire logic rx_sample = tick16 & (rx_ph == PHASE_SAMPLE);

  // Clocked-mode serial clock: toggles per tick while a transfer runs
  wire logic sy_run = sync & ((tx_state == TX_DATA) | (rx_state == RX_BITS));
  wire logic sy_fall = sync_int ? (tick_int & sy_sck_r & sy_run) : sck_fall;
  wire logic sy_rise = sync_int ? (tick_int & ~sy_sck_r) : sck_rise;
  wire logic sy_sck_nxt = ~sync_int ? 1'b1 :
                          (tick_int & (sy_run | ~sy_sck_r)) ? ~sy_sck_r : sy_sck_r;
  wire logic drive_async_clk = ~sync & ~ext_clk & ctrl_r.clock_source_lo;

  // Transmit load and end conditions
  wire logic tx_evt = sync ? sy_fall : bit_start;
  wire logic tx_final_async = ~sync & (tx_state == TX_STOP) & bit_start &
                              (~mode_r.stop_two | tstop2_r);
  wire logic tx_final_sync = sync & (tx_state == TX_DATA) & sy_fall & (tcnt == DATA_LAST_8);
  wire logic tx_load = te & ~stat_r.tx_data_empty_flag &
                       ((tx_state == TX_IDLE) | tx_final_async | tx_final_sync);
  wire logic tx_end = te & stat_r.tx_data_empty_flag &
                      (tx_final_async | (sync & (tx_state == TX_STOP) & sy_rise));
  wire logic [7:0] tx_word = seven ? {1'b0, tdr_r[6:0]} : tdr_r;

  // Receive completion and checks
  wire logic rx_err = stat_r.overrun_error_flag | stat_r.framing_error_flag |
                      stat_r.parity_error_flag;
  wire logic rx_done = re & (((rx_state == RX_STOP) & rx_sample & ~sync) |
                       (sync & (rx_state == RX_BITS) & sy_rise & (rcnt == DATA_LAST_8)));
  wire logic [7:0] rx_raw = sync ? {rxd, rsh_r[6:0]} :
                            seven ? {1'b0, rsh_r[6:0]} : rsh_r[7:0];
  wire logic rx_pbit = rsh_r[data_last + 4'h1];
  wire logic stop_bad = ~sync & ~rxd;
  wire logic par_bad = ~sync & mode_r.parity_enable & ~mode_r.multiproc_format_enable &
                       (^rx_raw ^ rx_pbit ^ mode_r.parity_odd);
  wire logic rx_load = rx_done & ~stat_r.rx_data_full_flag;

  // APB answer: pready high in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~addr_ok;
      if (setup) prdata_r <= pwrite ? '0 : rd_data;
    end
  end

  // Software-owned registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
      ctrl_r <= CTRL_RESET;
      brate_r <= BRATE_RESET;
      tdr_r <= '0;
      order_r <= 1'b0;
    end else begin
      if (wr_mode) mode_r <= mode_t'(pwdata[7:0]);
      if (wr_ctrl) ctrl_r <= ctrl_t'(pwdata[7:0]);
      if (wr_brate) brate_r <= pwdata[7:0];
      if (wr_tdr) tdr_r <= pwdata[7:0];
      if (wr_order) order_r <= pwdata[ORDER_BIT_POS];
    end
  end

  // Status flags: software writes 0 to clear, except tx-end which a transmit load clears; a hardware set wins the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= STATUS_RESET;
      brk_r <= 1'b0;
    end else begin
      stat_r.tx_data_empty_flag <= (stat_r.tx_data_empty_flag & ~(wr_stat &
        ~wst.tx_data_empty_flag)) | tx_load | ~te;
      stat_r.tx_end_flag <= (stat_r.tx_end_flag & ~tx_load) | tx_end | ~te;
      if (wr_stat) stat_r.mp_bit_transmit <= wst.mp_bit_transmit;
      stat_r.rx_data_full_flag <= (stat_r.rx_data_full_flag & ~(wr_stat &
        ~wst.rx_data_full_flag)) | (rx_load & ~stop_bad & ~par_bad);
      stat_r.overrun_error_flag <= (stat_r.overrun_error_flag & ~(wr_stat &
        ~wst.overrun_error_flag)) | (rx_done & stat_r.rx_data_full_flag);
      stat_r.framing_error_flag <= (stat_r.framing_error_flag & ~(wr_stat &
        ~wst.framing_error_flag)) | (rx_load & stop_bad);
      stat_r.parity_error_flag <= (stat_r.parity_error_flag & ~(wr_stat &
        ~wst.parity_error_flag)) | (rx_load & par_bad);
      brk_r <= (brk_r & ~(wr_stat & ~wst.framing_error_flag)) |
               (rx_load & stop_bad & ~|rx_raw & ~(extra & rx_pbit));
      if (rx_load & ~sync & mode_r.multiproc_format_enable)
        stat_r.mp_bit_received <= rx_pbit;
    end
  end

  // Received data: kept when receive enable drops; overrun leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdr_r <= '0;
    else if (rx_load) rdr_r <= bit_order(rx_raw, seven, order_r);
  end

  // Baud generator, line sampling and 16x phase counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
      brg_cnt <= '0;
      tx_ph <= '0;
      rxd_q <= 1'b1;
      sck_in_q <= 1'b1;
      sy_sck_r <= 1'b1;
    end else begin
      pre_cnt <= pre_wrap ? '0 : pre_cnt + 7'h01;
      if (pre_wrap) brg_cnt <= (brg_cnt == brate_r) ? '0 : brg_cnt + 8'h01;
      tx_ph <= tx_ph_nxt;
      rxd_q <= rxd;
      sck_in_q <= sck_in;
      sy_sck_r <= sy_sck_nxt;
    end
  end

  // Transmitter; dropping transmit enable returns it to mark at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      txd_r <= 1'b1;
      tsh_r <= '0;
      tcnt <= '0;
      tpar_r <= 1'b0;
      tmpb_r <= 1'b0;
      tstop2_r <= 1'b0;
    end else if (!te) begin
      tx_state <= TX_IDLE;
      txd_r <= 1'b1;
      tsh_r <= '0;
      tcnt <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: ;
        TX_START: if (bit_start) begin
          txd_r <= 1'b0;
          tx_state <= TX_DATA;
        end
        TX_DATA: if (tx_evt) begin
          txd_r <= tsh_r[0];
          tsh_r <= tsh_r >> 1;
          tcnt <= tcnt + 4'h1;
          if (tcnt == data_last) begin
            tstop2_r <= 1'b0;
            tx_state <= sync ? TX_STOP : (extra ? TX_PAR : TX_STOP);
          end
        end
        TX_PAR: if (bit_start) begin
          txd_r <= mode_r.multiproc_format_enable ? tmpb_r : tpar_r;
          tx_state <= TX_STOP;
        end
        TX_STOP: begin
          if (sync & sy_rise) tx_state <= TX_IDLE;
          if (~sync & bit_start) begin
            txd_r <= 1'b1;
            tstop2_r <= 1'b1;
            if (tx_final_async) tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
      if (tx_load) begin
        tsh_r <= bit_order(tx_word, seven, order_r);
        tpar_r <= ^tx_word ^ mode_r.parity_odd;
        tmpb_r <= stat_r.mp_bit_transmit;
        tcnt <= '0;
        tx_state <= sync ? TX_DATA : TX_START;
      end
    end
  end

  // Receiver; an error flag blocks new characters until it is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_ph <= '0;
      rcnt <= '0;
      rsh_r <= '0;
    end else if (!re) begin
      rx_state <= RX_IDLE;
      rcnt <= '0;
    end else begin
      if (tick16) rx_ph <= rx_ph + 4'h1;
      case (rx_state)
        RX_IDLE: if (!rx_err) begin
          rcnt <= '0;
          if (sync) begin
            if (~te | (tx_state != TX_IDLE)) rx_state <= RX_BITS;
          end else if (rxd_q & ~rxd) begin
            rx_ph <= '0;
            rx_state <= RX_START;
          end
        end
        RX_START: if (rx_sample) rx_state <= rxd ? RX_IDLE : RX_BITS;
        RX_BITS: begin
          if (sync ? sy_rise : rx_sample) begin
            rsh_r[rcnt] <= rxd;
            rcnt <= rcnt + 4'h1;
            if (sync & (rcnt == DATA_LAST_8)) rcnt <= '0;
            if (~sync & (rcnt == rcnt_last)) rx_state <= RX_STOP;
          end
        end
        RX_STOP: if (rx_sample) rx_state <= RX_IDLE;
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Pin drivers and request output, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_oe_r <= 1'b0;
      sck_oe_r <= 1'b0;
      sck_out_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      txd_oe_r <= te;
      sck_oe_r <= drive_async_clk | sync_int;
      sck_out_r <= sync ? sy_sck_nxt : tx_ph_nxt[3];
      irq_r <= ctrl_r.tx_empty_irq_enable & stat_r.tx_data_empty_flag;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txd = txd_r;
  assign txd_oe = txd_oe_r;
  assign sck_out = sck_out_r;
  assign sck_oe = sck_oe_r;
  assign tx_empty_irq = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_te_clear;
    wr_ctrl & ~pwdata[5] |=> ##1 stat_r.tx_data_empty_flag & stat_r.tx_end_flag & txd_r;
  endproperty
  a_te_clear: assert property (p_te_clear) else $error("tx disable did not reset");
  property p_load_sets_empty;
    tx_load |=> stat_r.tx_data_empty_flag && (tx_state == TX_START || tx_state == TX_DATA);
  endproperty
  a_load_sets_empty: assert property (p_load_sets_empty) else $error("load flow wrong");
  property p_start_low;
    te && tx_state == TX_START && bit_start |=> !txd_r ##0 tx_state == TX_DATA;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_mark_idle;
    !te |=> txd_r && tx_state == TX_IDLE;
  endproperty
  a_mark_idle: assert property (p_mark_idle) else $error("line not marking");
  property p_framing;
    rx_load && stop_bad |=> stat_r.framing_error_flag && !stat_r.rx_data_full_flag;
  endproperty
  a_framing: assert property (p_framing) else $error("framing error missed");
  property p_overrun;
    rx_done && stat_r.rx_data_full_flag |=> stat_r.overrun_error_flag && $stable(rdr_r);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun handling wrong");
  property p_re_keeps;
    !re && !wr_stat |=> $stable(rdr_r) && $stable(stat_r.rx_data_full_flag);
  endproperty
  a_re_keeps: assert property (p_re_keeps) else $error("rx state lost");
  property p_clk_start;
    wr_ctrl && !sync && pwdata[1:0] == 2'h1 |=> ##1 sck_oe_r;
  endproperty
  a_clk_start: assert property (p_clk_start) else $error("clock out late");
  property p_clk_mid;
    !sync && $rose(sck_out_r) |-> tx_ph == PHASE_MID;
  endproperty
  a_clk_mid: assert property (p_clk_mid) else $error("clock edge off centre");

  c_tx_frame: cover property (tx_final_async);
  c_rx_parity: cover property (rx_load && extra && !mode_r.multiproc_format_enable);
  c_sync_rx: cover property (rx_done && sync);
  c_overrun: cover property (rx_done && stat_r.rx_data_full_flag);

endmodule : serial_async_sync_framing

// [dv/serial_line_partner.sv]
// Remote serial device on the async line: sends and captures frames.
// Assumes a bit lasts BIT_CYC pclk cycles and the line pins are pclk-synchronous.
`timescale 1ns/1ps
module serial_line_partner #(
  parameter int BIT_CYC = 32
) (
  // Clock and line
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  // Line rests at mark; the model always drives a level on it, never floats
  initial rxd = 1'b1;

  // Low start bit, then ten line bits in order, then back to mark
  task automatic send(input logic [9:0] bits);
    int i;
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (i = 0; i < 10; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask : send

  // Wait for a start edge, check it mid-bit, then sample ten bits at centres
  task automatic recv(output logic [9:0] bits, output bit ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge pclk);
    ok = (n < 4000) && (txd === 1'b0);
    for (n = 0; n < 10; n++) begin
      repeat (BIT_CYC) @(negedge pclk);
      bits[n] = txd;
    end
  endtask : recv
endmodule : serial_line_partner

// [dv/serial_async_sync_framing_tb_top.sv]
// Top testbench: APB register tasks plus async line traffic via the partner.
// Assumes bit rate 0 and prescale 0, so one bit is 32 pclk cycles.
`timescale 1ns/1ps
module serial_async_sync_framing_tb_top;
  import serial_pkg::*;
  localparam int BIT_CYC = 32;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rxd, txd, txd_oe, sck_out, sck_oe, tx_empty_irq;
  logic sck_in = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0, n_checks = 0, cyc = 0;

  serial_async_sync_framing i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .sck_in(sck_in), .txd(txd),
    .txd_oe(txd_oe), .sck_out(sck_out), .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq));
  serial_line_partner #(.BIT_CYC(BIT_CYC)) i_partner (.pclk(pclk), .txd(txd), .rxd(rxd));

  always #4 pclk = ~pclk;

  // Free-running 16x source, one rise per two pclk, never stopped
  always @(posedge pclk) sck_in <= ~sck_in;

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // Line bits after the start bit: data LSB first, optional extra bit, then ones
  function automatic logic [9:0] frame(input logic [7:0] d, input int nb, input logic ext,
                                        input logic pb);
    logic [9:0] f;
    f = '1;
    for (int i = 0; i < nb; i++) f[i] = d[i];
    if (ext) f[nb] = pb;
    return f;
  endfunction : frame

  initial begin
    logic [31:0] q;
    logic e;
    logic [9:0] got;
    bit ok;
    logic [7:0] m;
    logic [7:0] d;
    logic [7:0] dx;
    logic [7:0] modes [6];
    int k;
    modes = '{8'h00, 8'h68, 8'h0C, 8'h60, 8'h00, 8'h00};
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, q);
    check("mode reset", q, {24'h0, MODE_RESET});
    rd(OFS_BRATE, q);
    check("bit rate reset", q, {24'h0, BRATE_RESET});
    rd(OFS_STATUS, q);
    check("status reset", {24'h0, q[7:0]}, {24'h0, STATUS_RESET});
    apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    $display("test reset values done");
    // Each format: disable, set clock, format, rate, wait a bit, enable, send
    // Pass 4 sends MSB first, pass 5 runs on the external 16x clock
    for (k = 0; k < 6; k++) begin
      m = modes[k];
      d = 8'hA5 ^ 8'(k * 8'h33);
      for (int i = 0; i < 8; i++) dx[i] = (k == 4) ? d[7 - i] : d[i];
      wr(OFS_CTRL, (k == 5) ? 32'h2 : 32'h0); // Clock source first
      wr(OFS_MODE, {24'h0, m});
      wr(OFS_ORDER, 32'(k == 4) << ORDER_BIT_POS);
      wr(OFS_BRATE, 32'h0);
      repeat (BIT_CYC) @(posedge pclk);
      wr(OFS_CTRL, (k == 5) ? 32'h22 : 32'h20);
      // Pin enable is registered off the control register, two edges on
      repeat (2) @(posedge pclk);
      check("txd_oe", {31'h0, txd_oe}, 32'h1);
      check("txd mark", {31'h0, txd}, 32'h1);
      wr(OFS_TXDATA, {24'h0, d});
      fork
        i_partner.recv(got, ok);
        wr(OFS_STATUS, 32'h79);
      join
      check("start bit", {31'h0, ok}, 32'h1);
      check("frame", {22'h0, got}, {22'h0, frame(dx, m[6] ? 7 : 8, m[5] | m[2],
        m[2] ? 1'b1 : ^(d & (m[6] ? 8'h7F : 8'hFF)))});
    end
    // Queue a second byte behind a busy shifter, then drop transmit enable
    wr(OFS_STATUS, 32'h79);
    wr(OFS_STATUS, 32'h79);
    rd(OFS_STATUS, q);
    check("tx empty busy", {31'h0, q[7]}, 32'h0);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, q);
    check("tx empty on disable", {31'h0, q[7]}, 32'h1);
    check("txd after disable", {31'h0, txd}, 32'h1);
    // Port logic owns the pin once released, so software can hold a break
    check("txd released", {31'h0, txd_oe}, 32'h0);
    wr(OFS_CTRL, 32'h81);
    rd(OFS_STATUS, q);
    check("clock out enable", {31'h0, sck_oe}, 32'h1);
    check("tx empty request", {31'h0, tx_empty_irq}, 32'h1);
    // Clocked mode, internal clock: capture txd on each rising serial clock
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MODE, 32'h80);
    repeat (BIT_CYC) @(posedge pclk);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_TXDATA, 32'hC6);
    fork
      for (int j = 0; j < 8; j++) begin
        @(posedge sck_out);
        m[j] = txd;
      end
      wr(OFS_STATUS, 32'h78);
    join
    check("sync data", {24'h0, m}, 32'hC6);
    check("sync clock out", {31'h0, sck_oe}, 32'h1);
    $display("test transmit done");
    // Receive, overrun, then disable keeps flags and data
    wr(OFS_CTRL, 32'h0);
    wr(OFS_MODE, 32'h0);
    repeat (BIT_CYC) @(posedge pclk);
    wr(OFS_CTRL, 32'h10);
    i_partner.send(frame(8'h3C, 8, 1'b0, 1'b0));
    rd(OFS_STATUS, q);
    check("rx flags", {28'h0, q[6:3]}, 32'h8);
    i_partner.send(frame(8'hC3, 8, 1'b0, 1'b0));
    rd(OFS_STATUS, q);
    check("overrun flags", {28'h0, q[6:3]}, 32'hC);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, q);
    check("flags kept", {28'h0, q[6:3]}, 32'hC);
    rd(OFS_RXDATA, q);
    check("rx data kept", q, 32'h3C);
    // All-zero character with a low stop bit is a framing error and a break
    wr(OFS_STATUS, 32'h87);
    wr(OFS_CTRL, 32'h10);
    i_partner.send(10'h000);
    rd(OFS_STATUS, q);
    check("break flags", {26'h0, q[8:3]}, 32'h32);
    $display("test receive done");
    tally_and_finish();
  end
endmodule : serial_async_sync_framing_tb_top
